// >>> bench/quadrature_digital_upconverter_src.sv
// Purpose: baseband source model, sends I then Q words
// Assumes: word handshake of quadrature_digital_upconverter_top on sys_clk
// Notes: idle data toggles each cycle so a stale word never passes
`timescale 1ns/1ps
module quadrature_digital_upconverter_src
   import quadrature_digital_upconverter_pkg::*;
(
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic en, // keep sending pairs
   input wire quadrature_digital_upconverter_iq_t iq, // pair to send
   input wire logic word_ready, // device takes word
   output logic word_valid, // word offered
   output logic signed [15:0] word_data // I or Q word
);
   quadrature_digital_upconverter_slot_t slot_q;
   // ==================================================
   // word sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word_data <= 16'h0000;
         slot_q <= QUADRATURE_DIGITAL_UPCONVERTER_WANT_I;
      end else if (word_valid && word_ready) begin
         slot_q <= quadrature_digital_upconverter_slot_t'(~slot_q);
         // an I already taken always gets its Q
         word_valid <= en || (slot_q == QUADRATURE_DIGITAL_UPCONVERTER_WANT_I);
         word_data <= (slot_q == QUADRATURE_DIGITAL_UPCONVERTER_WANT_I) ? iq.q : iq.i;
      end else if (!word_valid) begin
         word_valid <= en;
         word_data <= en ? iq.i : ~word_data;
      end
   end
endmodule

// >>> bench/quadrature_digital_upconverter_top_test.sv
// Purpose: self-checking bench of the upconverter datapath
// Assumes: constant baseband pair, so a settled output is a pure tone
// Notes: t_tone and t_scale sample windows start a multiple of 32 edges apart
`timescale 1ns/1ps
module quadrature_digital_upconverter_top_test
   import quadrature_digital_upconverter_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b0;
   logic tune_load = 1'b0;
   logic isinc_en = 1'b0;
   quadrature_digital_upconverter_iq_t iq = '0;
   logic [31:0] tune_word = 32'h0000_0000;
   logic [31:0] phase_offset = 32'h0000_0000;
   logic [7:0] amp_scale = 8'h80;
   logic word_valid, word_ready, word_slot_q;
   logic signed [15:0] word_data, dac_data;
   int err_total = 0;
   int n_checks = 0;
   always #4 sys_clk = ~sys_clk;
   quadrature_digital_upconverter_top u_quadrature_digital_upconverter_top (.sys_clk(sys_clk), .rst_n(rst_n), .word_valid(word_valid),
      .word_data(word_data), .word_ready(word_ready), .word_slot_q(word_slot_q),
      .tune_word(tune_word), .phase_offset(phase_offset), .tune_load(tune_load),
      .isinc_en(isinc_en), .amp_scale(amp_scale), .dac_data(dac_data));
   quadrature_digital_upconverter_src u_quadrature_digital_upconverter_src (.sys_clk(sys_clk), .rst_n(rst_n), .en(en), .iq(iq),
      .word_ready(word_ready), .word_valid(word_valid), .word_data(word_data));
   // ==================================================
   // helpers
   task automatic chk_bit(string nm, logic e, logic g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk_val(string nm, logic signed [15:0] e, logic signed [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %0d got %0d", nm, e, g);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   function automatic logic near(logic signed [15:0] x, logic signed [15:0] y);
      logic signed [17:0] d;
      d = x + y;
      return (d <= 4) && (d >= -4);
   endfunction
   function automatic logic big(logic signed [15:0] x);
      return (x > 16) || (x < -16);
   endfunction
   task automatic wait_for(logic slot, logic v);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (((slot ? word_slot_q : word_ready) !== v) && n < 64);
      if (n >= 64) begin
         err_total++;
         $display("CHECK FAILED handshake exp %b got timeout", v);
         end_sim;
      end
   endtask
   task automatic grab(output logic signed [15:0] s[32]);
      for (int k = 0; k < 32; k++) begin
         @(posedge sys_clk);
         #1;
         s[k] = dac_data;
      end
   endtask
   task automatic retune(logic [31:0] ftw, logic [31:0] ph);
      @(posedge sys_clk);
      tune_word <= ftw;
      phase_offset <= ph;
      tune_load <= 1'b1;
      @(posedge sys_clk);
      tune_load <= 1'b0;
      repeat (300) @(posedge sys_clk);
   endtask
   // ==================================================
   // scenarios
   task automatic t_reset;
      chk_bit("word_ready", 1'b0, word_ready);
      chk_bit("word_slot_q", 1'b0, word_slot_q);
      chk_val("dac_data", 16'sh0000, dac_data);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk_bit("word_ready", 1'b1, word_ready);
      $display("test reset done");
   endtask
   task automatic t_frame;
      int n;
      @(posedge sys_clk);
      iq <= '{i: 16'sh4000, q: 16'sh0000};
      en <= 1'b1;
      wait_for(1'b1, 1'b1);
      wait_for(1'b0, 1'b0);
      chk_bit("word_slot_q", 1'b0, word_slot_q);
      n = 0;
      while (word_ready === 1'b0 && n < 64) begin
         n++;
         @(posedge sys_clk);
         #1;
      end
      chk_val("ready_low", 16'sd14, 16'(n));
      if (n >= 64) end_sim;
      $display("test frame done");
   endtask
   task automatic t_tone(logic [31:0] ftw, int per);
      logic signed [15:0] a[32], b[32];
      logic pk, df;
      pk = 1'b0;
      df = 1'b0;
      retune(ftw, 32'h0000_0000);
      grab(a);
      @(posedge sys_clk);
      isinc_en <= 1'b1;
      repeat (31) @(posedge sys_clk);
      grab(b);
      for (int k = 0; k < 32 - per; k++) begin
         chk_val("period", a[k], a[k + per]);
         chk_val("period_isinc", b[k], b[k + per]);
      end
      for (int k = 0; k < per; k++) begin
         chk_bit("antiphase", 1'b1, near(a[k], a[k + per / 2]));
         pk = pk | big(a[k]);
         df = df | (a[k] != b[k]);
      end
      chk_bit("tone_present", 1'b1, pk);
      chk_bit("isinc_effect", 1'b1, df);
      @(posedge sys_clk);
      isinc_en <= 1'b0;
      $display("test tone done");
   endtask
   task automatic t_scale;
      logic signed [15:0] a[32], b[32], z[32];
      retune(32'h2000_0000, 32'h0000_0000);
      grab(a);
      @(posedge sys_clk);
      amp_scale <= 8'h40;
      repeat (31) @(posedge sys_clk);
      grab(b);
      @(posedge sys_clk);
      amp_scale <= 8'h00;
      repeat (31) @(posedge sys_clk);
      grab(z);
      for (int k = 0; k < 8; k++) begin
         chk_bit("half_gain", 1'b1, near(a[k], -(b[k] * 2)));
         chk_val("silence", 16'sh0000, z[k]);
      end
      @(posedge sys_clk);
      amp_scale <= 8'h80;
      $display("test scale done");
   endtask
   task automatic t_phase;
      logic signed [15:0] a[32], b[32];
      // mid-run reset parks the accumulator at zero phase, so the held tone is at its peak
      @(posedge sys_clk);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_bit("word_ready_rst", 1'b0, word_ready);
      chk_val("dac_rst", 16'sh0000, dac_data);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      retune(32'h0000_0000, 32'h0000_0000);
      grab(a);
      retune(32'h0000_0000, 32'h8000_0000);
      grab(b);
      chk_bit("phase_flip", 1'b1, near(a[0], b[0]) && big(a[0]));
      $display("test phase done");
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      t_reset;
      t_frame;
      t_tone(32'h2000_0000, 8);
      t_tone(32'h1000_0000, 16);
      t_scale;
      t_phase;
      end_sim;
   end
endmodule

// >>> logic/quadrature_digital_upconverter_interp.sv
// Purpose: half-band cascade then comb-integrator interpolator for one rail
// Assumes: in_valid at most once per OUT_RATE cycles; output one sample per clock
// Notes: half-bands are short zero-stuff plus [1 2 1]/2 smoothing sections
`timescale 1ns/1ps
`include "quadrature_digital_upconverter_defines.svh"
module quadrature_digital_upconverter_interp
   import quadrature_digital_upconverter_pkg::*;
#(
   parameter int W = `QUADRATURE_DIGITAL_UPCONVERTER_IQ_W,
   parameter int HB = `QUADRATURE_DIGITAL_UPCONVERTER_HB_STAGES,
   parameter int CIC_R = `QUADRATURE_DIGITAL_UPCONVERTER_CIC_RATE
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic in_valid, // new baseband sample
   input wire logic signed [W-1:0] in_data, // baseband sample
   output logic signed [W-1:0] out_data // interpolated sample, every clock
);
   localparam int OUT_RATE = CIC_R << HB;
   localparam int CW = W + 2 + $clog2(OUT_RATE);
   initial begin
      if (HB < 1 || CIC_R < 2 || (CIC_R & (CIC_R - 1)) != 0)
         $error("quadrature_digital_upconverter_interp: bad interpolation setup");
   end
   // ==================================================
   // half-band chain: each stage doubles rate via a strobe phase
   logic [$clog2(OUT_RATE)-1:0] ph_q, ph_d;
   logic signed [W-1:0] st [0:HB];
   logic signed [W-1:0] hb_q [1:HB];
   logic signed [W-1:0] hbp_q [1:HB];
   logic signed [W-1:0] hb_d [1:HB];
   logic signed [W-1:0] hbp_d [1:HB];
   assign st[0] = in_data;
   always_comb begin
      ph_d = in_valid ? '0 : ph_q + 1'b1;
   end
   genvar g;
   generate
      for (g = 1; g <= HB; g++) begin : g_hb
         localparam int STEP = OUT_RATE >> g;
         logic signed [W+1:0] acc;
         always_comb begin
            hb_d[g] = hb_q[g];
            hbp_d[g] = hbp_q[g];
            acc = '0;
            if (ph_q % STEP == 0) begin
               // even phase carries the new sample, odd phase the midpoint
               if ((ph_q / STEP) % 2 == 0) begin
                  hbp_d[g] = st[g-1];
                  acc = {{2{st[g-1][W-1]}}, st[g-1]};
               end else begin
                  acc = {{2{hbp_q[g][W-1]}}, hbp_q[g]} + {{2{st[g-1][W-1]}}, st[g-1]};
                  acc = acc >>> 1;
               end
               hb_d[g] = acc[W-1:0];
            end
         end
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               hb_q[g] <= '0;
               hbp_q[g] <= '0;
            end else begin
               hb_q[g] <= hb_d[g];
               hbp_q[g] <= hbp_d[g];
            end
         end
         assign st[g] = hb_q[g];
      end
   endgenerate
   // ==================================================
   // comb at the half-band rate, integrator at full rate, unity gain so no scaling applied
   logic signed [CW-1:0] comb_prev_q, comb_prev_d, comb_q, comb_d, integ_q, integ_d;
   always_comb begin
      comb_prev_d = comb_prev_q;
      comb_d = comb_q;
      if (ph_q % CIC_R == 0) begin
         comb_prev_d = CW'(st[HB]);
         comb_d = CW'(st[HB]) - comb_prev_q;
      end
      integ_d = integ_q + ((ph_q % CIC_R == 0) ? comb_q : '0);
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= '0;
         comb_prev_q <= '0;
         comb_q <= '0;
         integ_q <= '0;
         out_data <= '0;
      end else begin
         ph_q <= ph_d;
         comb_prev_q <= comb_prev_d;
         comb_q <= comb_d;
         integ_q <= integ_d;
         out_data <= integ_q[W-1:0];
      end
   end
endmodule

// >>> logic/quadrature_digital_upconverter_top.sv
// Contract
// R1: source sends I then Q words, 250 Mword/s max
// R2: half-band cascade then comb-integrator interpolation
// R3: 32-bit tuned oscillator gives cosine and sine
// R4: modulator outputs real carrier at oscillator frequency
// R5: inverse-sinc correction, selectable or bypassed
// R6: programmable amplitude scale before converter
// R7: post-interpolation path runs every system clock
// R8: retune of frequency and phase takes effect quickly
// R9: accumulator adds tuning word modulo 2^32 each clock
//
// Purpose: quadrature digital upconverter transmit datapath
// Assumes: interleaved words from logic on sys_clk; no register bus
// Notes: oscillator uses a quarter-wave-free 64-entry sine table
`timescale 1ns/1ps
`include "quadrature_digital_upconverter_defines.svh"
module quadrature_digital_upconverter_top
   import quadrature_digital_upconverter_pkg::*;
#(
   parameter int W = `QUADRATURE_DIGITAL_UPCONVERTER_IQ_W,
   parameter int SW = `QUADRATURE_DIGITAL_UPCONVERTER_SCALE_W
) (
   input wire logic sys_clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic word_valid, // baseband word present
   input wire logic signed [W-1:0] word_data, // I or Q word
   output logic word_ready, // word taken this cycle
   output logic word_slot_q, // 1 when next word taken is Q
   input wire logic [`QUADRATURE_DIGITAL_UPCONVERTER_FTW_W-1:0] tune_word, // oscillator tuning word
   input wire logic [`QUADRATURE_DIGITAL_UPCONVERTER_PHASE_W-1:0] phase_offset, // oscillator phase offset
   input wire logic tune_load, // one-cycle strobe: apply tuning
   input wire logic isinc_en, // enable inverse-sinc correction
   input wire logic [SW-1:0] amp_scale, // gain, 0x80 is unity
   output logic signed [W-1:0] dac_data // sample to converter
);
   localparam int RATE = `QUADRATURE_DIGITAL_UPCONVERTER_CIC_RATE << `QUADRATURE_DIGITAL_UPCONVERTER_HB_STAGES;
   localparam int GW = $clog2(RATE);
   initial begin
      if (W < 8 || SW < 2 || `QUADRATURE_DIGITAL_UPCONVERTER_CLK_MHZ > `QUADRATURE_DIGITAL_UPCONVERTER_MAX_CLK_MHZ)
         $error("quadrature_digital_upconverter_top: unsupported configuration");
   end
   // ==================================================
   // input framing: I word, then Q word, then a wait to the pair slot
   quadrature_digital_upconverter_slot_t slot_q, slot_d;
   logic [$clog2(RATE)-1:0] gap_q, gap_d;
   logic signed [W-1:0] ihold_q, ihold_d;
   quadrature_digital_upconverter_iq_t pair_q, pair_d;
   logic pair_v_q, pair_v_d;
   logic take;
   assign take = word_valid && word_ready;
   always_comb begin
      slot_d = slot_q;
      ihold_d = ihold_q;
      pair_d = pair_q;
      pair_v_d = 1'b0;
      gap_d = (gap_q != '0) ? gap_q - 1'b1 : gap_q;
      if (take) begin // R1
         if (slot_q == QUADRATURE_DIGITAL_UPCONVERTER_WANT_I) begin
            ihold_d = word_data;
            slot_d = QUADRATURE_DIGITAL_UPCONVERTER_WANT_Q;
         end else begin
            pair_d.i = ihold_q;
            pair_d.q = word_data;
            pair_v_d = 1'b1;
            slot_d = QUADRATURE_DIGITAL_UPCONVERTER_WANT_I;
            gap_d = GW'(RATE - 2);
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_q <= QUADRATURE_DIGITAL_UPCONVERTER_WANT_I;
         gap_q <= '0;
         ihold_q <= '0;
         pair_q <= '0;
         pair_v_q <= 1'b0;
         word_ready <= 1'b0;
         word_slot_q <= 1'b0;
      end else begin
         slot_q <= slot_d;
         gap_q <= gap_d;
         ihold_q <= ihold_d;
         pair_q <= pair_d;
         pair_v_q <= pair_v_d;
         // one pair per RATE clocks keeps the interpolator phase aligned
         word_ready <= (gap_d == '0); // R1
         word_slot_q <= (slot_d == QUADRATURE_DIGITAL_UPCONVERTER_WANT_Q);
      end
   end
   // ==================================================
   // interpolation per rail
   logic signed [W-1:0] up_i, up_q;
   quadrature_digital_upconverter_interp #(.W(W)) u_interp_i ( // R2
      .sys_clk(sys_clk), .rst_n(rst_n), .in_valid(pair_v_q),
      .in_data(pair_q.i), .out_data(up_i));
   quadrature_digital_upconverter_interp #(.W(W)) u_interp_q ( // R2
      .sys_clk(sys_clk), .rst_n(rst_n), .in_valid(pair_v_q),
      .in_data(pair_q.q), .out_data(up_q));
   // ==================================================
   // oscillator
   logic [`QUADRATURE_DIGITAL_UPCONVERTER_FTW_W-1:0] ftw_q, ftw_d;
   logic [`QUADRATURE_DIGITAL_UPCONVERTER_PHASE_W-1:0] pofs_q, pofs_d, acc_q, acc_d, ph;
   always_comb begin
      ftw_d = tune_load ? tune_word : ftw_q; // R8
      pofs_d = tune_load ? phase_offset : pofs_q; // R8
      acc_d = acc_q + ftw_q; // R9
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ftw_q <= '0;
         pofs_q <= '0;
         acc_q <= '0;
      end else begin
         ftw_q <= ftw_d;
         pofs_q <= pofs_d;
         acc_q <= acc_d; // R7
      end
   end
   assign ph = acc_q + pofs_q;
   function automatic logic signed [W-1:0] sin_lut(input logic [`QUADRATURE_DIGITAL_UPCONVERTER_LUT_BITS-1:0] a);
      real x;
      x = $sin(2.0 * 3.14159265358979 * a / 64.0) * (2.0 ** (W - 2) - 1.0);
      return W'($rtoi(x));
   endfunction
   logic signed [W-1:0] lut [0:63];
   generate
      for (genvar k = 0; k < 64; k++) begin : g_lut
         assign lut[k] = sin_lut(6'(k));
      end
   endgenerate
   logic [5:0] pi_idx;
   assign pi_idx = ph[`QUADRATURE_DIGITAL_UPCONVERTER_PHASE_W-1 -: `QUADRATURE_DIGITAL_UPCONVERTER_LUT_BITS];
   // ==================================================
   // modulator: I*cos - Q*sin, scaled back to W bits
   logic signed [W-1:0] cos_q, sin_q, mod_q, mod_d;
   logic signed [2*W:0] prod;
   always_comb begin
      // widen before multiplying so the product keeps all its bits
      prod = (2*W+1)'(up_i) * (2*W+1)'(cos_q) - (2*W+1)'(up_q) * (2*W+1)'(sin_q); // R3 R4
      mod_d = prod[2*W-1 -: W];
   end
   // ==================================================
   // inverse sinc: [-1 18 -1]/16 three-tap peaking, then scale
   logic signed [W-1:0] d1_q, d2_q, isx_q, isx_d, out_d;
   logic signed [W+5:0] tap;
   logic signed [W+SW:0] sc;
   always_comb begin
      tap = (W+6)'(18 * (W+6)'(d1_q) - (W+6)'(mod_q) - (W+6)'(d2_q));
      isx_d = isinc_en ? tap[W+3:4] : d1_q; // R5
      sc = (W+SW+1)'(isx_q) * $signed({1'b0, amp_scale}); // R6
      out_d = sc[W+SW-2 -: W];
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cos_q <= '0;
         sin_q <= '0;
         mod_q <= '0;
         d1_q <= '0;
         d2_q <= '0;
         isx_q <= '0;
         dac_data <= '0;
      end else begin
         cos_q <= lut[6'(pi_idx + 6'h10)]; // R3
         sin_q <= lut[pi_idx]; // R3
         mod_q <= mod_d; // R7
         d1_q <= mod_q;
         d2_q <= d1_q;
         isx_q <= isx_d;
         dac_data <= out_d; // R6
      end
   end
   // ==================================================
   // checks
   property p_acc_step;
      @(posedge sys_clk) disable iff (!rst_n)
         acc_q == $past(acc_q) + $past(ftw_q);
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("accumulator step wrong"); // R9
   property p_tune;
      @(posedge sys_clk) disable iff (!rst_n) tune_load |=> ftw_q == $past(tune_word);
   endproperty
   a_tune: assert property (p_tune) else $error("tuning word not applied"); // R8
   sequence s_i_taken;
      word_valid && word_ready && !word_slot_q;
   endsequence
   property p_pair;
      @(posedge sys_clk) disable iff (!rst_n) s_i_taken |=> word_slot_q;
   endproperty
   a_pair: assert property (p_pair) else $error("Q slot not following I"); // R1
   property p_bypass;
      @(posedge sys_clk) disable iff (!rst_n) !isinc_en |=> isx_q == $past(d1_q);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass path wrong"); // R5
   property p_unity;
      @(posedge sys_clk) disable iff (!rst_n)
         amp_scale == `QUADRATURE_DIGITAL_UPCONVERTER_SCALE_ONE |=> dac_data == $past(isx_q);
   endproperty
   a_unity: assert property (p_unity) else $error("unity scale altered sample"); // R6
   property p_zero;
      @(posedge sys_clk) disable iff (!rst_n) amp_scale == '0 |=> dac_data == '0;
   endproperty
   a_zero: assert property (p_zero) else $error("zero scale not silent"); // R6
   property p_mod;
      @(posedge sys_clk) disable iff (!rst_n) (up_q == '0 && up_i == '0) |=> mod_q == '0;
   endproperty
   a_mod: assert property (p_mod) else $error("modulator leaks carrier"); // R4
   property p_pair_v;
      @(posedge sys_clk) disable iff (!rst_n) pair_v_q |=> !pair_v_q [*2];
   endproperty
   a_pair_v: assert property (p_pair_v) else $error("pairs too close"); // R2
endmodule

// >>> shared/quadrature_digital_upconverter_defines.svh
// Purpose: constants of the quadrature digital upconverter datapath
// Assumes: 125 MHz system clock
// Notes: timing and width figures only; types live in the package
`ifndef QUADRATURE_DIGITAL_UPCONVERTER_DEFINES_SVH
`define QUADRATURE_DIGITAL_UPCONVERTER_DEFINES_SVH
// ==================================================
// widths
`define QUADRATURE_DIGITAL_UPCONVERTER_IQ_W 16
`define QUADRATURE_DIGITAL_UPCONVERTER_FTW_W 32
`define QUADRATURE_DIGITAL_UPCONVERTER_PHASE_W 32
`define QUADRATURE_DIGITAL_UPCONVERTER_LUT_BITS 6
`define QUADRATURE_DIGITAL_UPCONVERTER_SCALE_W 8
`define QUADRATURE_DIGITAL_UPCONVERTER_SCALE_ONE 8'h80
// ==================================================
// rates
`define QUADRATURE_DIGITAL_UPCONVERTER_CLK_MHZ 125
`define QUADRATURE_DIGITAL_UPCONVERTER_MAX_CLK_MHZ 1000
`define QUADRATURE_DIGITAL_UPCONVERTER_MAX_WORD_MSPS 250
// cycles of ready per input word: words arrive no faster than one per clock
`define QUADRATURE_DIGITAL_UPCONVERTER_WORD_CYCLES ((`QUADRATURE_DIGITAL_UPCONVERTER_CLK_MHZ + `QUADRATURE_DIGITAL_UPCONVERTER_MAX_WORD_MSPS - 1) / `QUADRATURE_DIGITAL_UPCONVERTER_MAX_WORD_MSPS)
// ==================================================
// interpolation: two half-band stages (x2 each) then comb-integrator x R
`define QUADRATURE_DIGITAL_UPCONVERTER_HB_STAGES 2
`define QUADRATURE_DIGITAL_UPCONVERTER_CIC_RATE 4
`endif

// >>> shared/quadrature_digital_upconverter_pkg.sv
// Purpose: shared types of the upconverter
// Assumes: quadrature_digital_upconverter_defines.svh constants
// Notes: sample pair travels as one packed struct
`include "quadrature_digital_upconverter_defines.svh"
package quadrature_digital_upconverter_pkg;
   // ==================================================
   // baseband pair
   typedef struct packed {
      logic signed [`QUADRATURE_DIGITAL_UPCONVERTER_IQ_W-1:0] i;
      logic signed [`QUADRATURE_DIGITAL_UPCONVERTER_IQ_W-1:0] q;
   } quadrature_digital_upconverter_iq_t;
   // ==================================================
   // input word framing
   typedef enum logic [0:0] {
      QUADRATURE_DIGITAL_UPCONVERTER_WANT_I = 1'b0,
      QUADRATURE_DIGITAL_UPCONVERTER_WANT_Q = 1'b1
   } quadrature_digital_upconverter_slot_t;
endpackage
